// >>> lcd_output_format_control.v
// Contract
// - Two-bit field picks YCbCr-to-RGB matrix or bypass; bypass suits ITU-656.
// - RGB layer data is converted to YCbCr when YCbCr output is used.
// - Control bit 7 inverts the dot clock pin.
// - Control bit 6: data enable active high at 0, low at 1.
// - Control bit 5: vsync active low at 0, high at 1.
// - Control bit 4: hsync active low at 0, high at 1.
// - Format 0000: 24 parallel bits, red top byte.
// - Format 0001: six-bit RGB packed, upper bits zero.
// - Format 0010: RGB565 packed, upper eight bits zero.
// - Format 0100: green-blue word then red byte, upper lines zero.
// - Format 1000: blue, green, red bytes on low eight lines.
// - Format 1100: blue, green, red bytes then one dummy transfer.
// - Bit 31 enables layer zero luma/RGB upscale start offset.
// - Bit 30 enables layer zero luma/RGB downscale start offset.
// - Bit 29 enables layer zero chroma upscale start offset.
// - Bit 28 enables layer zero chroma downscale start offset.
// - Bit 27 enables layer one upscale start offset.
// - Bit 26 enables layer one downscale start offset.
// - Bit 25 forces pixel data black, sync timing kept.
// - Bit 24 blanks syncs and data enable; set after reset.
// - Offsets are eight-bit fractions of a line, value over 0x100.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "lcd_out_defines.vh"
module lcd_output_format_control (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    input wire pix_clk_i,
    input wire [23:0] pix_i,
    input wire pix_valid_i,
    input wire pix_is_rgb_i,
    input wire layer_cover_i,
    input wire hsync_i,
    input wire vsync_i,
    input wire den_i,
    output reg [23:0] lcd_data_o,
    output reg lcd_dclk_o,
    output reg lcd_hsync_o,
    output reg lcd_vsync_o,
    output reg lcd_den_o,
    output reg [7:0] l0y_up_ofs_o,
    output reg [7:0] l0y_dn_ofs_o,
    output reg [7:0] l0c_up_ofs_o,
    output reg [7:0] l0c_dn_ofs_o,
    output reg [7:0] l1_up_ofs_o,
    output reg [7:0] l1_dn_ofs_o
);
    reg [31:0] ctrl0_q;
    reg [31:0] ctrl1_q;
    reg [31:0] defl_q;
    reg [2:0] clk_sync_q;
    reg [1:0] beat_q;
    reg [23:0] cur_q;
    wire [23:0] csc_pix;
    wire [3:0] fmt = ctrl0_q[3:0];
    wire [1:0] csc = ctrl0_q[9:8];
    wire pclk_s = clk_sync_q[1];
    wire rise = pclk_s & ~clk_sync_q[2];
    wire ycc_out = (fmt == `FMT_656);
    // Registers
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ctrl0_q <= `CTRL_ZERO_RESET;
            // Blank set after reset
            // blank reset value
            ctrl1_q <= `CTRL_ONE_RESET;
            defl_q <= `DEFLICKER_RESET;
            rdata_o <= 32'h00000000;
        end else begin
            if (wr_i && addr_i == `REG_CTRL_ZERO)
                ctrl0_q <= wdata_i & `CTRL_ZERO_MASK;
            if (wr_i && addr_i == `REG_CTRL_ONE)
                ctrl1_q <= wdata_i;
            if (wr_i && addr_i == `REG_DEFLICKER)
                defl_q <= wdata_i;
            rdata_o <= 32'h00000000;
            if (rd_i) begin
                case (addr_i)
                `REG_CTRL_ZERO: rdata_o <= ctrl0_q;
                `REG_CTRL_ONE: rdata_o <= ctrl1_q;
                `REG_DEFLICKER: rdata_o <= defl_q;
                default: rdata_o <= 32'h00000000;
                endcase
            end
        end
    end
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            l0y_up_ofs_o <= 8'h00;
            l0y_dn_ofs_o <= 8'h00;
            l0c_up_ofs_o <= 8'h00;
            l0c_dn_ofs_o <= 8'h00;
            l1_up_ofs_o <= 8'h00;
            l1_dn_ofs_o <= 8'h00;
        end else begin
            l0y_up_ofs_o <= ctrl1_q[`BIT_L0Y_UP] ? defl_q[15:8] : 8'h00;
            l0y_dn_ofs_o <= ctrl1_q[`BIT_L0Y_DN] ? defl_q[7:0] : 8'h00;
            l0c_up_ofs_o <= ctrl1_q[`BIT_L0C_UP] ? defl_q[15:8] : 8'h00;
            l0c_dn_ofs_o <= ctrl1_q[`BIT_L0C_DN] ? defl_q[7:0] : 8'h00;
            l1_up_ofs_o <= ctrl1_q[`BIT_L1_UP] ? defl_q[31:24] : 8'h00;
            l1_dn_ofs_o <= ctrl1_q[`BIT_L1_DN] ? defl_q[23:16] : 8'h00;
        end
    end
    // RGB to YCbCr when 656 output
    // RGB layer data must not pass a YCbCr matrix on the way to an RGB bus
    lcd_csc u_csc (
        .sys_clk_i(sys_clk_i),
        .mode_i(pix_is_rgb_i ? `CSC_BYPASS : csc),
        .to_ycc_i(ycc_out & pix_is_rgb_i),
        .pix_i(pix_i),
        .pix_o(csc_pix)
    );
    // Pixel clock comes from another domain; two flops before the edge detector
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            clk_sync_q <= 3'h0;
        end else begin
            clk_sync_q <= {clk_sync_q[1:0], pix_clk_i};
        end
    end
    // Converter output lags input by one cycle, so sampled one cycle after the edge
    reg rise_d_q;
    reg cover_q;
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rise_d_q <= 1'b0;
            cover_q <= 1'b0;
        end else begin
            rise_d_q <= rise;
            cover_q <= layer_cover_i;
        end
    end
    // Output packing, one transfer per rising pixel-clock edge
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            beat_q <= 2'h0;
            cur_q <= 24'h000000;
            lcd_data_o <= 24'h000000;
            lcd_dclk_o <= 1'b0;
            lcd_hsync_o <= 1'b1;
            lcd_vsync_o <= 1'b1;
            lcd_den_o <= 1'b0;
        end else begin
            lcd_dclk_o <= pclk_s ^ ctrl0_q[`BIT_DCLK_INV];
            if (rise_d_q) begin
                if (ctrl1_q[`BIT_BLANK]) begin
                    lcd_hsync_o <= ~ctrl0_q[`BIT_HS_POL];
                    lcd_vsync_o <= ~ctrl0_q[`BIT_VS_POL];
                    lcd_den_o <= ctrl0_q[`BIT_DEN_INV];
                end else begin
                    lcd_hsync_o <= ~(hsync_i ^ ctrl0_q[`BIT_HS_POL]);
                    lcd_vsync_o <= ~(vsync_i ^ ctrl0_q[`BIT_VS_POL]);
                    lcd_den_o <= den_i ^ ctrl0_q[`BIT_DEN_INV];
                end
                if (beat_q == 2'h0) begin
                    if (ctrl1_q[`BIT_BLACK] || !pix_valid_i)
                        cur_q <= 24'h000000;
                    else if (!cover_q)
                        cur_q <= ctrl1_q[23:0];
                    else
                        cur_q <= csc_pix;
                end
                case (fmt)
                `FMT_P888: begin
                    beat_q <= 2'h0;
                    lcd_data_o <= cur_q;
                end
                `FMT_P666: begin
                    beat_q <= 2'h0;
                    lcd_data_o <= {6'h00, cur_q[23:18], cur_q[15:10], cur_q[7:2]};
                end
                `FMT_P565: begin
                    beat_q <= 2'h0;
                    lcd_data_o <= {8'h00, cur_q[23:19], cur_q[15:10], cur_q[7:3]};
                end
                `FMT_S2X16: begin
                    beat_q <= (beat_q == 2'h0) ? 2'h1 : 2'h0;
                    if (beat_q == 2'h0)
                        lcd_data_o <= {8'h00, cur_q[15:0]};
                    else
                        lcd_data_o <= {16'h0000, cur_q[23:16]};
                end
                `FMT_656: begin
                    beat_q <= 2'h0;
                    lcd_data_o <= {16'h0000, cur_q[23:16]};
                end
                `FMT_S3X8, `FMT_S3X8D: begin
                    if (beat_q == 2'h2 && fmt == `FMT_S3X8)
                        beat_q <= 2'h0;
                    else
                        beat_q <= beat_q + 2'h1;
                    case (beat_q)
                    2'h0: lcd_data_o <= {16'h0000, cur_q[7:0]};
                    2'h1: lcd_data_o <= {16'h0000, cur_q[15:8]};
                    2'h2: lcd_data_o <= {16'h0000, cur_q[23:16]};
                    default: lcd_data_o <= 24'h000000;
                    endcase
                end
                default: begin
                    beat_q <= 2'h0;
                    lcd_data_o <= 24'h000000;
                end
                endcase
            end
        end
    end
endmodule

// >>> lcd_out_defines.vh
// Offsets, field positions, reset values and encodings of the LCD output stage
`ifndef LCD_OUT_DEFINES_VH
`define LCD_OUT_DEFINES_VH
`define REG_CTRL_ZERO 8'h1C
`define REG_CTRL_ONE 8'h20
`define REG_DEFLICKER 8'h18
`define CTRL_ZERO_RESET 32'h00000000
`define CTRL_ONE_RESET 32'h01000000
`define DEFLICKER_RESET 32'h00000000
`define CTRL_ZERO_MASK 32'h000003FF
`define BIT_DCLK_INV 7
`define BIT_DEN_INV 6
`define BIT_VS_POL 5
`define BIT_HS_POL 4
`define BIT_L0Y_UP 31
`define BIT_L0Y_DN 30
`define BIT_L0C_UP 29
`define BIT_L0C_DN 28
`define BIT_L1_UP 27
`define BIT_L1_DN 26
`define BIT_BLACK 25
`define BIT_BLANK 24
`define CSC_MPEG 2'h0
`define CSC_JPEG 2'h1
`define CSC_HDTV 2'h2
`define CSC_BYPASS 2'h3
`define FMT_P888 4'h0
`define FMT_P666 4'h1
`define FMT_P565 4'h2
`define FMT_S2X16 4'h4
`define FMT_656 4'h6
`define FMT_S3X8 4'h8
`define FMT_S3X8D 4'hC
`endif

// >>> lcd_csc.v
// Colour-space converter: YCbCr to RGB by matrix, or RGB to YCbCr
`timescale 1ns/1ps
`include "lcd_out_defines.vh"
module lcd_csc (
    input wire sys_clk_i,
    input wire [1:0] mode_i,
    input wire to_ycc_i,
    input wire [23:0] pix_i,
    output reg [23:0] pix_o
);
    // Fixed-point coefficients scaled by 256
    function [7:0] sat;
        input signed [19:0] v;
        begin
            if (v < 0)
                sat = 8'h00;
            else if (v > 20'sd65280)
                sat = 8'hFF;
            else
                sat = v[15:8];
        end
    endfunction
    wire signed [19:0] a = {12'h000, pix_i[23:16]};
    wire signed [19:0] b = {12'h000, pix_i[15:8]};
    wire signed [19:0] c = {12'h000, pix_i[7:0]};
    reg signed [19:0] y;
    reg signed [19:0] u;
    reg signed [19:0] v;
    always @* begin
        y = a;
        u = b - 20'sd128;
        v = c - 20'sd128;
        if (mode_i == `CSC_MPEG)
            y = a - 20'sd16;
    end
    always @(posedge sys_clk_i) begin
        if (to_ycc_i) begin
            pix_o <= {sat(66 * a + 129 * b + 25 * c + 20'sd4096),
                      sat(-38 * a - 74 * b + 112 * c + 20'sd32768),
                      sat(112 * a - 94 * b - 18 * c + 20'sd32768)};
        end else begin
            case (mode_i)
            `CSC_MPEG: begin
                pix_o <= {sat(298 * y + 409 * v), sat(298 * y - 100 * u - 208 * v),
                          sat(298 * y + 516 * u)};
            end
            `CSC_JPEG: begin
                pix_o <= {sat(256 * y + 359 * v), sat(256 * y - 88 * u - 183 * v),
                          sat(256 * y + 454 * u)};
            end
            `CSC_HDTV: begin
                pix_o <= {sat(298 * y + 459 * v), sat(298 * y - 55 * u - 136 * v),
                          sat(298 * y + 541 * u)};
            end
            default: begin
                pix_o <= pix_i;
            end
            endcase
        end
    end
endmodule

// >>> lcd_output_format_control_assertions.sv
// Port checker for the LCD output stage
`timescale 1ns/1ps
`include "lcd_out_defines.vh"
module lcd_ofc_chk (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [31:0] rdata_o,
    input wire pix_clk_i,
    input wire [23:0] lcd_data_o,
    input wire lcd_dclk_o,
    input wire lcd_hsync_o,
    input wire lcd_vsync_o,
    input wire lcd_den_o,
    input wire [7:0] l0y_dn_ofs_o,
    input wire [7:0] l1_up_ofs_o
);
    reg [31:0] c0_q, c1_q, df_q;
    reg [5:0] quiet_q;
    wire [31:0] exp_rd = addr_i == `REG_CTRL_ZERO ? c0_q : addr_i == `REG_CTRL_ONE ? c1_q :
        addr_i == `REG_DEFLICKER ? df_q : 32'h0;
    wire [3:0] fmt = c0_q[3:0];
    wire [23:0] hi_m = fmt == `FMT_P666 ? 24'hFC0000 : fmt == `FMT_P565 ? 24'hFF0000 :
        fmt == `FMT_S2X16 ? 24'hFF0000 : (fmt[3] || fmt == `FMT_656) ? 24'hFFFF00 : 24'h0;
    // Settings stable long enough for a pixel edge to pass through
    wire q = quiet_q == 6'h3F;
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            c0_q <= `CTRL_ZERO_RESET;
            c1_q <= `CTRL_ONE_RESET;
            df_q <= `DEFLICKER_RESET;
            quiet_q <= 6'h00;
        end else if (wr_i) begin
            quiet_q <= 6'h00;
            if (addr_i == `REG_CTRL_ZERO)
                c0_q <= wdata_i & `CTRL_ZERO_MASK;
            if (addr_i == `REG_CTRL_ONE)
                c1_q <= wdata_i;
            if (addr_i == `REG_DEFLICKER)
                df_q <= wdata_i;
        end else if (!q) begin
            quiet_q <= quiet_q + 6'h01;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence dclk_move;
        ##[1:6] ($changed(lcd_dclk_o) && lcd_dclk_o != c0_q[`BIT_DCLK_INV]);
    endsequence
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data not idle");
    read_back_a: assert property (rd_i |=> rdata_o == $past(exp_rd))
        else $error("read data wrong");
    black_out_a: assert property (q && c1_q[`BIT_BLACK] |-> lcd_data_o == 24'h0)
        else $error("black mode data");
    blank_sync_a: assert property (q && c1_q[`BIT_BLANK] |->
        lcd_hsync_o == !c0_q[`BIT_HS_POL] && lcd_vsync_o == !c0_q[`BIT_VS_POL]
        && lcd_den_o == c0_q[`BIT_DEN_INV]) else $error("blank mode syncs");
    l1_up_ofs_a: assert property (q |-> l1_up_ofs_o == (c1_q[`BIT_L1_UP] ? df_q[31:24] : 8'h0))
        else $error("layer one up offset");
    l0_dn_ofs_a: assert property (q |-> l0y_dn_ofs_o == (c1_q[`BIT_L0Y_DN] ? df_q[7:0] : 8'h0))
        else $error("layer zero down offset");
    dclk_pol_a: assert property ($rose(pix_clk_i) && q |-> dclk_move or ##[1:6] !q)
        else $error("dot clock polarity");
    upper_zero_a: assert property (q |-> (lcd_data_o & hi_m) == 24'h0)
        else $error("upper data lines set");
endmodule

// >>> panel_model.sv
// Panel model: latches the pixel bus on each falling dot clock edge
`timescale 1ns/1ps
module panel_model (
    input wire sys_clk_i,
    input wire dclk_i,
    input wire [23:0] data_i,
    output reg got_o,
    output reg [23:0] word_o
);
    reg dclk_q = 1'b0;
    initial got_o = 1'b0;
    always @(posedge sys_clk_i) begin
        dclk_q <= dclk_i;
        // Mid-period latch, data settle after rise
        got_o <= dclk_q && !dclk_i;
        word_o <= data_i;
    end
endmodule

// >>> lcd_output_format_control_test.sv
// Testbench for the LCD output stage
`timescale 1ns/1ps
`include "lcd_out_defines.vh"
module lcd_output_format_control_test;
    reg sys_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, pix_clk_i = 1'b0;
    reg [7:0] addr_i = 8'h00;
    reg [31:0] wdata_i = 32'h0, v;
    reg [23:0] pix_i = 24'h0, p;
    reg layer_cover_i = 1'b1, hsync_i = 1'b0, vsync_i = 1'b0, den_i = 1'b0, rd_q = 1'b0;
    reg rgb_i = 1'b1;
    wire [31:0] rdata_o;
    wire [23:0] lcd_data_o, word;
    wire dclk, got, l0, l1;
    integer n_errors = 0, n_compared = 0, seed = 32'h3A3A;
    reg [31:0] rd_exp[$];
    reg [23:0] px_exp[$];
    lcd_output_format_control lcd_output_format_control_i (.sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .pix_clk_i(pix_clk_i), .pix_i(pix_i), .pix_valid_i(1'b1),
        .pix_is_rgb_i(rgb_i), .layer_cover_i(layer_cover_i), .hsync_i(hsync_i),
        .vsync_i(vsync_i), .den_i(den_i), .lcd_data_o(lcd_data_o), .lcd_dclk_o(dclk),
        .lcd_hsync_o(), .lcd_vsync_o(), .lcd_den_o(), .l0y_up_ofs_o(), .l0y_dn_ofs_o(),
        .l0c_up_ofs_o(), .l0c_dn_ofs_o(), .l1_up_ofs_o(), .l1_dn_ofs_o());
    panel_model panel_model_i (.sys_clk_i(sys_clk_i), .dclk_i(dclk), .data_i(lcd_data_o),
        .got_o(got), .word_o(word));
    initial forever #4 sys_clk_i = ~sys_clk_i;
    initial forever #62.5 pix_clk_i = ~pix_clk_i;
    always @(posedge sys_clk_i) begin
        {hsync_i, vsync_i, den_i} <= $random(seed);
        rd_q <= rd_i;
        if (rd_q) cmp_rd(rd_exp.pop_front());
        if (got && px_exp.size() > 0) cmp_px(px_exp.pop_front());
    end
    task cmp_rd(input [31:0] e);
        begin
            n_compared = n_compared + 1;
            if (rdata_o !== e) begin
                n_errors = n_errors + 1;
                $display("[FAIL] rdata exp %h got %h", e, rdata_o);
            end
        end
    endtask
    task cmp_px(input [23:0] e);
        begin
            n_compared = n_compared + 1;
            if (word !== e) begin
                n_errors = n_errors + 1;
                $display("[FAIL] pixel exp %h got %h", e, word);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge sys_clk_i);
            wr_i <= 1'b0;
            @(posedge sys_clk_i);
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            rd_exp.push_back(e);
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge sys_clk_i);
            rd_i <= 1'b0;
            @(posedge sys_clk_i);
        end
    endtask
    // Pixel held steady so every captured beat must match
    task px(input [9:0] f, input [31:0] c1, input [23:0] d, input cov, input [23:0] e);
        integer i;
        begin
            wr(`REG_CTRL_ZERO, {22'h0, f});
            wr(`REG_CTRL_ONE, c1);
            pix_i <= d;
            layer_cover_i <= cov;
            repeat (64) @(posedge sys_clk_i);
            repeat (3) px_exp.push_back(e);
            for (i = 0; i < 300 && px_exp.size() > 0; i = i + 1)
                @(posedge sys_clk_i);
            if (px_exp.size() > 0) begin
                n_errors = n_errors + 1;
                $display("[FAIL] pixel exp %h got none", e);
            end
            $display("test format %h done", f);
        end
    endtask
    task stop_test;
        begin
            $display("compared %0d errors %0d", n_compared, n_errors);
            if (n_errors == 0 && n_compared > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        #400000;
        n_errors = n_errors + 1;
        stop_test;
    end
    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (80) @(posedge sys_clk_i);
        rd(`REG_CTRL_ONE, `CTRL_ONE_RESET);
        rd(`REG_CTRL_ZERO, `CTRL_ZERO_RESET);
        v = $random(seed);
        wr(`REG_CTRL_ONE, v);
        rd(`REG_CTRL_ONE, v);
        wr(`REG_CTRL_ZERO, v);
        rd(`REG_CTRL_ZERO, v & `CTRL_ZERO_MASK);
        v = $random(seed);
        wr(`REG_DEFLICKER, v);
        rd(`REG_DEFLICKER, v);
        rd(8'h44, 32'h0);
        wr(`REG_CTRL_ONE, 32'hFC000000);
        wr(`REG_CTRL_ZERO, 32'h00000080);
        repeat (100) @(posedge sys_clk_i);
        $display("test registers done");
        p = $random(seed);
        px(`FMT_P888, 32'h0, p, 1'b1, p);
        px(`FMT_P666, 32'h0, p, 1'b1, {6'h0, p[23:18], p[15:10], p[7:2]});
        px(`FMT_P565, 32'h0, p, 1'b1, {8'h0, p[23:19], p[15:10], p[7:3]});
        px(`FMT_S3X8, 32'h0, {3{p[7:0]}}, 1'b1, {16'h0, p[7:0]});
        px(`FMT_P888, {8'h02, p}, p, 1'b1, 24'h0);
        px(`FMT_P888, {8'h00, ~p}, p, 1'b0, ~p);
        rgb_i <= 1'b0;
        px({`CSC_MPEG, 4'h0, `FMT_P888}, 32'h0, 24'h108080, 1'b1, 24'h0);
        px({`CSC_JPEG, 4'h0, `FMT_P888}, 32'h0, 24'h808080, 1'b1, 24'h808080);
        stop_test;
    end
endmodule
bind lcd_output_format_control lcd_ofc_chk lcd_ofc_chk_i (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .pix_clk_i(pix_clk_i), .lcd_data_o(lcd_data_o),
    .lcd_dclk_o(lcd_dclk_o), .lcd_hsync_o(lcd_hsync_o), .lcd_vsync_o(lcd_vsync_o),
    .lcd_den_o(lcd_den_o), .l0y_dn_ofs_o(l0y_dn_ofs_o), .l1_up_ofs_o(l1_up_ofs_o));
